// ---- hdl/lan_status_pkg.sv ----
// Purpose: shared constants for the lan status readout and receive trailer block
// Assumes: one clock, host command/status port, one dma write port
// Notes: codes below are those the host decodes from status byte 0
// Contract
// - command 0fh with pointer 0 restarts status reads
// - each status read advances the pointer by one
// - after acknowledge, load next pending event, reassert interrupt
// - byte 0: bit 7 unacknowledged, low nibble event
// - codes 8,4,12,1,2,5,6 for the seven events
// - raise receive event after frame fully stored
// - keep receiving while dma grants requests
// - frames stored at consecutive addresses, back to back
// - status trailer then byte count after data
// - byte count is last item per frame
// - 16-bit mode: odd frame skips one byte
// - count covers addresses, info, two status bytes
// - 16-bit mode widens each trailer byte to word
// - command bit 7 acknowledges the interrupt
// - status bytes frozen until interrupt acknowledged
// - one receive event covers all frames until acknowledge; code merges only frames completed before the event loads into status
package lan_status_pkg;
  localparam logic [3:0] CMD_STATUS_PTR  = 4'hf;
  localparam int         CMD_ACK_BIT     = 7;
  localparam int         PTR_FIELD_LSB   = 4;
  localparam int         PTR_FIELD_W     = 3;
  localparam int         STATUS_BYTES    = 6;
  localparam int         INT_FLAG_BIT    = 7;
  localparam logic [3:0] EVT_RECEIVE     = 4'h8;
  localparam logic [3:0] EVT_TX_DONE     = 4'h4;
  localparam logic [3:0] EVT_RETRANSMIT  = 4'hc;
  localparam logic [3:0] EVT_ADDR_SET    = 4'h1;
  localparam logic [3:0] EVT_CONFIG_DONE = 4'h2;
  localparam logic [3:0] EVT_CABLE_TEST  = 4'h5;
  localparam logic [3:0] EVT_DUMP_DONE   = 4'h6;
  localparam logic [15:0] BC_STATUS_BYTES = 16'h0002;
  localparam logic [31:0] RX_BASE_RESET  = 32'h0000_0000;
  localparam int         TRAILER_ENTRIES = 4;
endpackage

// ---- hdl/dma_word_writer.sv ----
// Purpose: one-entry holding register for dma writes with request/grant
// Assumes: grant pulses one cycle while request is high
// Notes: busy stays high from load until grant
`timescale 1ns/10ps
module dma_word_writer #(
  parameter int ADDR_W = 16
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_load,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [15:0]       i_data,
  input  wire logic [1:0]        i_be,
  input  wire logic              i_grant,
  output logic                   o_req,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [15:0]            o_data,
  output logic [1:0]             o_be
);
  initial begin
    if (ADDR_W < 2 || ADDR_W > 32) $error("ADDR_W out of range");
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req <= 1'b0;
    end else if (i_ce) begin
      if (i_load) begin
        o_req <= 1'b1;
      end else if (i_grant) begin
        o_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_addr <= '0;
      o_data <= 16'h0000;
      o_be   <= 2'h0;
    end else if (i_ce && i_load) begin
      o_addr <= i_addr;
      o_data <= i_data;
      o_be   <= i_be;
    end
  end
endmodule // dma_word_writer

// ---- hdl/lan_status_rx.sv ----
// Purpose: host status readout with event queue, and receive frame store to memory
// Assumes: host port and frame stream synchronous to i_core_clk
// Notes: trailer order per frame is status 0, status 1, count low, count high
`timescale 1ns/10ps
module lan_status_rx
  import lan_status_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_bus16,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [7:0]             o_rdata,
  output logic                   o_int,
  input  wire logic              i_evt_valid,
  input  wire logic [3:0]        i_evt_code,
  input  wire logic [39:0]       i_evt_info,
  output logic                   o_evt_ready,
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  input  wire logic              i_rx_last,
  input  wire logic [15:0]       i_rx_status,
  output logic                   o_rx_ready,
  output logic                   o_dma_req,
  output logic [ADDR_W-1:0]      o_dma_addr,
  output logic [15:0]            o_dma_data,
  output logic [1:0]             o_dma_be,
  input  wire logic              i_dma_grant,
  output logic                   o_frame_done,
  output logic [15:0]            o_bc_addr
);
  initial begin
    if (ADDR_W < 16 || ADDR_W > 32) $error("ADDR_W must be 16..32");
    if (STATUS_BYTES > (1 << PTR_FIELD_W)) $error("status pointer field too narrow");
    if (PTR_FIELD_LSB + PTR_FIELD_W > CMD_ACK_BIT) $error("pointer field overlaps ack bit");
    if (TRAILER_ENTRIES != 4) $error("trailer sequencer serves four entries");
    if (INT_FLAG_BIT > 7) $error("interrupt flag outside status byte");
  end

  typedef enum logic [1:0] {ST_DATA, ST_TRAIL, ST_FINISH} rx_state_t;

  rx_state_t         state;
  logic [7:0]        status_byte [STATUS_BYTES];
  logic [2:0]        rd_ptr;
  logic              ptr_valid;
  logic              cmd_pend;
  logic [3:0]        cmd_code;
  logic [39:0]       cmd_info;
  logic              rx_pend;
  logic [7:0]        rx_merged;
  logic [ADDR_W-1:0] wr_addr;
  logic              half_full;
  logic [7:0]        half_byte;
  logic [15:0]       byte_cnt;
  logic [15:0]       frm_status;
  logic [1:0]        trail_idx;
  logic              wr_load;
  logic [15:0]       wr_data;
  logic [1:0]        wr_be;
  logic [ADDR_W-1:0] step;
  logic              take_byte;
  logic              wr_free;
  logic              cmd_wr;
  logic              ack;
  logic              load_evt;
  logic [7:0]        trail_byte;

  assign cmd_wr      = i_ce && i_wr;
  assign ack         = cmd_wr && i_wdata[CMD_ACK_BIT];
  assign load_evt    = i_ce && !status_byte[0][INT_FLAG_BIT] && (rx_pend || cmd_pend);
  assign o_int       = status_byte[0][INT_FLAG_BIT];
  assign o_evt_ready = !cmd_pend;
  assign wr_free     = !o_dma_req;
  assign step        = i_bus16 ? ADDR_W'(2) : ADDR_W'(1);
  // frames keep flowing as long as the dma drains the write slot
  assign o_rx_ready  = i_ce && (state == ST_DATA) && wr_free;
  assign take_byte   = o_rx_ready && i_rx_valid;

  // status pointer and read data
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_ptr    <= 3'h0;
      ptr_valid <= 1'b0;
      o_rdata   <= 8'h00;
    end else if (i_ce) begin
      if (cmd_wr) begin
        if (i_wdata[3:0] == CMD_STATUS_PTR) begin
          rd_ptr    <= i_wdata[PTR_FIELD_LSB +: PTR_FIELD_W];
          ptr_valid <= 1'b1;
        end else begin
          ptr_valid <= 1'b0;
        end
      end else if (i_rd) begin
        if (ptr_valid && int'(rd_ptr) < STATUS_BYTES) begin
          o_rdata <= status_byte[rd_ptr];
        end else begin
          o_rdata <= 8'h00;
        end
        rd_ptr <= (int'(rd_ptr) >= STATUS_BYTES - 1) ? 3'h0 : rd_ptr + 3'h1;
      end
    end
  end

  // one-deep queue for command completion events
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_pend <= 1'b0;
      cmd_code <= 4'h0;
      cmd_info <= 40'h00_0000_0000;
    end else if (i_ce) begin
      if (i_evt_valid && !cmd_pend) begin
        cmd_pend <= 1'b1;
        cmd_code <= i_evt_code;
        cmd_info <= i_evt_info;
      end else if (load_evt && !rx_pend) begin
        cmd_pend <= 1'b0;
      end
    end
  end

  // receive event: frames completed while pending merge into one
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_pend   <= 1'b0;
      rx_merged <= 8'h00;
    end else if (i_ce) begin
      if (o_frame_done) begin
        rx_pend <= 1'b1;
        if (load_evt && rx_pend) begin
          rx_merged <= 8'h01;
        end else if (rx_merged != 8'hff) begin
          rx_merged <= rx_merged + 8'h01;
        end
      end else if (load_evt && rx_pend) begin
        rx_pend   <= 1'b0;
        rx_merged <= 8'h00;
      end
    end
  end

  // status bytes: frozen while the interrupt flag stands
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < STATUS_BYTES; k++) begin
        status_byte[k] <= 8'h00;
      end
    end else if (i_ce) begin
      if (load_evt) begin
        if (rx_pend) begin
          status_byte[0] <= {1'b1, 3'h0, EVT_RECEIVE};
          status_byte[1] <= rx_merged;
          status_byte[2] <= frm_status[7:0];
          status_byte[3] <= frm_status[15:8];
          status_byte[4] <= o_bc_addr[7:0];
          status_byte[5] <= o_bc_addr[15:8];
        end else begin
          status_byte[0] <= {1'b1, 3'h0, cmd_code};
          for (int k = 1; k < STATUS_BYTES; k++) begin
            status_byte[k] <= cmd_info[(k-1)*8 +: 8];
          end
        end
      end else if (ack) begin
        status_byte[0][INT_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // trailer entry selection
  always_comb begin
    case (trail_idx)
      2'd0:    trail_byte = frm_status[7:0];
      2'd1:    trail_byte = frm_status[15:8];
      2'd2:    trail_byte = byte_cnt[7:0];
      default: trail_byte = byte_cnt[15:8];
    endcase
  end

  // write slot load and packing
  always_comb begin
    wr_load = 1'b0;
    wr_data = 16'h0000;
    wr_be   = 2'h0;
    if (take_byte) begin
      if (!i_bus16) begin
        wr_load = 1'b1;
        wr_data = {8'h00, i_rx_data};
        wr_be   = 2'h1;
      end else if (half_full) begin
        wr_load = 1'b1;
        wr_data = {i_rx_data, half_byte};
        wr_be   = 2'h3;
      end else if (i_rx_last) begin
        wr_load = 1'b1;
        wr_data = {8'h00, i_rx_data};
        wr_be   = 2'h1;
      end
    end else if (i_ce && state == ST_TRAIL && wr_free) begin
      wr_load = 1'b1;
      wr_data = {8'h00, trail_byte};
      wr_be   = i_bus16 ? 2'h3 : 2'h1;
    end
  end

  // receive stream sequencing
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state        <= ST_DATA;
      wr_addr      <= RX_BASE_RESET[ADDR_W-1:0];
      half_full    <= 1'b0;
      half_byte    <= 8'h00;
      byte_cnt     <= 16'h0000;
      frm_status   <= 16'h0000;
      trail_idx    <= 2'h0;
      o_frame_done <= 1'b0;
      o_bc_addr    <= 16'h0000;
    end else if (i_ce) begin
      o_frame_done <= 1'b0;
      if (wr_load) begin
        wr_addr <= wr_addr + step;
      end
      case (state)
        ST_DATA: begin
          if (take_byte) begin
            byte_cnt <= byte_cnt + 16'h0001;
            if (i_bus16 && !half_full && !i_rx_last) begin
              half_full <= 1'b1;
              half_byte <= i_rx_data;
            end else begin
              half_full <= 1'b0;
            end
            if (i_rx_last) begin
              byte_cnt   <= byte_cnt + 16'h0001 + BC_STATUS_BYTES;
              frm_status <= i_rx_status;
              trail_idx  <= 2'h0;
              state      <= ST_TRAIL;
            end
          end
        end
        ST_TRAIL: begin
          if (wr_load) begin
            trail_idx <= trail_idx + 2'h1;
            if (int'(trail_idx) == TRAILER_ENTRIES - 1) begin
              o_bc_addr <= wr_addr[15:0];
              state     <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          if (wr_free) begin
            o_frame_done <= 1'b1;
            byte_cnt     <= 16'h0000;
            state        <= ST_DATA;
          end
        end
        default: state <= ST_DATA;
      endcase
    end
  end

  dma_word_writer #(
    .ADDR_W (ADDR_W)
  ) u_writer (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_ce       (i_ce),
    .i_load     (wr_load),
    .i_addr     (wr_addr),
    .i_data     (wr_data),
    .i_be       (wr_be),
    .i_grant    (i_dma_grant),
    .o_req      (o_dma_req),
    .o_addr     (o_dma_addr),
    .o_data     (o_dma_data),
    .o_be       (o_dma_be)
  );
endmodule // lan_status_rx

// ---- bench/lan_status_rx_chk.sv ----
// Purpose: port assertions for lan_status_rx
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/10ps
module lan_status_rx_chk #(
  parameter int ADDR_W = 16
) (
  input wire logic              i_core_clk,
  input wire logic              i_resetn,
  input wire logic              i_ce,
  input wire logic              i_bus16,
  input wire logic [7:0]        i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [7:0]        o_rdata,
  input wire logic              o_int,
  input wire logic              o_rx_ready,
  input wire logic              o_dma_req,
  input wire logic [ADDR_W-1:0] o_dma_addr,
  input wire logic [1:0]        o_dma_be,
  input wire logic              i_dma_grant,
  input wire logic              o_frame_done,
  input wire logic [15:0]       o_bc_addr
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_ack;
    o_int && i_ce && i_wr && i_wdata[7];
  endsequence
  sequence s_wait;
    o_dma_req && !i_dma_grant;
  endsequence
  property p_ack; s_ack |=> !o_int; endproperty
  a_ack: assert property (p_ack) else $error("int kept after ack");
  property p_hold; o_int && !(i_wr && i_wdata[7]) |=> o_int; endproperty
  a_hold: assert property (p_hold) else $error("int dropped");
  property p_rdat; !i_rd |=> $stable(o_rdata); endproperty
  a_rdat: assert property (p_rdat) else $error("read data moved");
  property p_req; s_wait |=> o_dma_req && $stable(o_dma_addr) && $stable(o_dma_be); endproperty
  a_req: assert property (p_req) else $error("request not held");
  property p_gnt; o_dma_req && i_dma_grant |=> !o_dma_req; endproperty
  a_gnt: assert property (p_gnt) else $error("request after grant");
  property p_done; o_frame_done |=> !o_frame_done; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_word; o_frame_done && i_bus16 |=> !o_bc_addr[0]; endproperty
  a_word: assert property (p_word) else $error("count not on word");
  property p_byte; o_dma_req && !i_bus16 |-> o_dma_be == 2'b01; endproperty
  a_byte: assert property (p_byte) else $error("byte mode be");
  property p_ce; !i_ce |-> !o_rx_ready; endproperty
  a_ce: assert property (p_ce) else $error("ready while frozen");
endmodule // lan_status_rx_chk

// ---- bench/dma_mem_model.sv ----
// Purpose: dma controller and memory with count address latch
// Assumes: one grant pulse per request
// Notes: slow mode grants only on odd cycles
`timescale 1ns/10ps
module dma_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_slow,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic [1:0]  i_be,
  input  wire logic        i_done,
  input  wire logic [15:0] i_bc,
  output logic             o_grant,
  output logic [15:0]      o_latch
);
  logic [7:0] mem [0:255] = '{default: 8'h5a};
  logic       phase;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_grant <= 1'b0;
      phase   <= 1'b0;
      o_latch <= 16'h0000;
    end else begin
      phase   <= ~phase;
      o_grant <= i_req && !o_grant && (!i_slow || phase);
      if (i_done) o_latch <= i_bc;
    end
  end
  // store granted bytes
  always @(posedge i_core_clk) begin
    if (o_grant && i_req && i_be[0]) mem[i_addr[7:0]] <= i_data[7:0];
    if (o_grant && i_req && i_be[1]) mem[i_addr[7:0]+8'h01] <= i_data[15:8];
  end
endmodule // dma_mem_model

// ---- bench/lan_status_rx_tb.sv ----
// Purpose: self-checking bench for lan_status_rx
// Assumes: host strobes and frame stream driven at rising edges
// Notes: memory contents read from the dma model
`timescale 1ns/10ps
module lan_status_rx_tb;
  import lan_status_pkg::*;
  logic clk, rstn, ce, bus16, wr, rd, evt_v, rx_v, rx_l, slow, gnt, done, req;
  logic [7:0]  wdata, rdata, rx_d;
  logic [3:0]  code;
  logic [39:0] info;
  logic [15:0] rx_st, addr, dat, bc, latch;
  logic [1:0]  be;
  logic        irq, evt_rdy, rx_rdy;
  int          error_cnt, n_checks, nx;
  logic [3:0]  codes [6] = '{4'h4, 4'hc, 4'h1, 4'h2, 4'h5, 4'h6};
  lan_status_rx dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_bus16(bus16),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_int(irq),
    .i_evt_valid(evt_v), .i_evt_code(code), .i_evt_info(info), .o_evt_ready(evt_rdy),
    .i_rx_valid(rx_v), .i_rx_data(rx_d), .i_rx_last(rx_l), .i_rx_status(rx_st),
    .o_rx_ready(rx_rdy), .o_dma_req(req), .o_dma_addr(addr), .o_dma_data(dat),
    .o_dma_be(be), .i_dma_grant(gnt), .o_frame_done(done), .o_bc_addr(bc));
  dma_mem_model mem_u (.i_core_clk(clk), .i_resetn(rstn), .i_slow(slow), .i_req(req),
    .i_addr(addr), .i_data(dat), .i_be(be), .i_done(done), .i_bc(bc),
    .o_grant(gnt), .o_latch(latch));
  always #2.5 clk = ~clk;
  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_eq(input bit sel, input logic [15:0] e);
    int t;
    t = 0;
    #1;
    while ((sel ? latch : {15'h0, irq}) !== e && t < 400) begin
      @(posedge clk);
      #1;
      t++;
    end
    if ((sel ? latch : {15'h0, irq}) !== e) begin
      chk(sel ? "latch" : "o_int", e, sel ? latch : {15'h0, irq});
      test_done();
    end
    @(posedge clk);
  endtask
  task automatic wr_cmd(input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("o_rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic offer(input logic [3:0] c);
    int t;
    t = 0;
    evt_v <= 1'b1;
    code <= c;
    do begin
      @(posedge clk);
      t++;
    end while (!evt_rdy && t < 400);
    evt_v <= 1'b0;
    if (!evt_rdy) begin
      chk("o_evt_ready", 16'h0001, {15'h0, evt_rdy});
      test_done();
    end
  endtask
  task automatic send(input int n, input logic [7:0] b0, input logic [15:0] st);
    int t;
    for (int i = 0; i < n; i++) begin
      rx_v <= 1'b1;
      rx_d <= b0 + 8'(i);
      rx_l <= (i == n - 1);
      rx_st <= st;
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (!rx_rdy && t < 400);
      if (!rx_rdy) begin
        chk("o_rx_ready", 16'h0001, {15'h0, rx_rdy});
        test_done();
      end
    end
  endtask
  task automatic chk_frame(input int a, input int n, input bit w, input logic [15:0] st,
                           input logic [7:0] b0, input bit lt);
    int s;
    int k;
    logic [7:0] tr [4];
    tr = '{st[7:0], st[15:8], 8'(n + 2), 8'h00};
    for (int i = 0; i < n; i++) chk("data", {8'h00, b0 + 8'(i)}, {8'h00, mem_u.mem[a+i]});
    s = w ? a + n + (n % 2) : a + n;
    for (k = 0; k < 4; k++) begin
      chk("trailer", {8'h00, tr[k]}, {8'h00, mem_u.mem[s+k*(w+1)]});
      if (w) chk("trailer_hi", 16'h0000, {8'h00, mem_u.mem[s+k*2+1]});
    end
    if (lt) chk("latch", 16'(s + 3 * (w + 1)), latch);
    nx = s + 4 * (w + 1);
  endtask
  initial begin
    {clk, rstn, bus16, wr, rd, evt_v, rx_v, rx_l, slow, code, rx_d, rx_st, wdata} = '0;
    ce = 1'b1;
    info = 40'h15_14_13_12_11;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (codes[j]) begin
      offer(codes[j]);
      wait_eq(0, 16'h1);
      wr_cmd(8'h0f);
      rd_chk({4'h8, codes[j]});
      for (int k = 1; k < 6; k++) rd_chk(8'h10 + 8'(k));
      wr_cmd(8'h80);
    end
    offer(4'h4);
    wait_eq(0, 16'h1);
    offer(4'h6);
    wr_cmd(8'h0f);
    rd_chk(8'h84);
    rd_chk(8'h11);
    wr_cmd(8'h00);
    rd_chk(8'h00);
    wr_cmd(8'h8f);
    wait_eq(0, 16'h1);
    wr_cmd(8'h0f);
    rd_chk(8'h86);
    wr_cmd(8'h80);
    send(3, 8'h30, 16'h2041);
    slow <= 1'b1;
    send(3, 8'h40, 16'h2042);
    rx_v <= 1'b0;
    wait_eq(1, 16'd13);
    slow <= 1'b0;
    wr_cmd(8'h0f);
    rd_chk(8'h88);
    rd_chk(8'h01);
    rd_chk(8'h41);
    rd_chk(8'h20);
    rd_chk(8'h06);
    wr_cmd(8'h80);
    wait_eq(0, 16'h1);
    wr_cmd(8'h0f);
    rd_chk(8'h88);
    rd_chk(8'h01);
    rd_chk(8'h42);
    rd_chk(8'h20);
    rd_chk(8'h0d);
    wr_cmd(8'h80);
    chk_frame(0, 3, 0, 16'h2041, 8'h30, 0);
    chk_frame(nx, 3, 0, 16'h2042, 8'h40, 1);
    bus16 <= 1'b1;
    send(3, 8'h50, 16'h2043);
    rx_v <= 1'b0;
    wait_eq(1, 16'd24);
    chk_frame(14, 3, 1, 16'h2043, 8'h50, 1);
    chk("skip", 16'h005a, {8'h00, mem_u.mem[17]});
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1 chk("o_rx_ready", 16'h0000, {15'h0, rx_rdy});
    @(posedge clk);
    ce <= 1'b1;
    test_done();
  end
endmodule // lan_status_rx_tb
bind lan_status_rx lan_status_rx_chk #(.ADDR_W(ADDR_W)) chk_u (.i_core_clk(i_core_clk),
  .i_resetn(i_resetn), .i_ce(i_ce), .i_bus16(i_bus16), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_int(o_int), .o_rx_ready(o_rx_ready),
  .o_dma_req(o_dma_req), .o_dma_addr(o_dma_addr), .o_dma_be(o_dma_be),
  .i_dma_grant(i_dma_grant), .o_frame_done(o_frame_done), .o_bc_addr(o_bc_addr));
